/* fcr_busy_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module fcr_busy_timer (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // start with a cycle count
  input  wire logic       i_start,
  input  wire logic [7:0] i_cycles,
  // status
  output logic            o_busy,
  output logic            o_done
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic       next_busy;
  logic       next_done;

  // one-shot countdown, done pulses the cycle busy falls
  always_comb begin
    next_count = count;
    next_busy  = o_busy;
    next_done  = 1'b0;
    if (i_start && !o_busy) begin
      next_count = i_cycles;
      next_busy  = 1'b1;
    end else if (o_busy) begin
      if (count <= 8'h01) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_count = 8'h00;
      end else begin
        next_count = count - 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      count  <= 8'h00;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      count  <= next_count;
      o_busy <= next_busy;
      o_done <= next_done;
    end
  end
endmodule : fcr_busy_timer
`default_nettype wire

/* fcr_config_one.sv */
// Operation
// - source bit 0: nonvolatile protect level rules, register write programs it slowly
// - delivered with source bit 0 and nonvolatile protect level 000
// - source bit 1: nonvolatile level becomes 111, volatile level loads 111 on reset
// - source bit 1: register write changes only volatile level, fast
// - an OTP bit at 1 ignores writes of 0, no program error
// - param location bit 1 places parameter sectors top, 0 bottom
// - uniform sector layout makes param location bit reserved, no effect
// - protect direction and param location are independent bits
// - nv width bit is volatile reset default; nv instruction mode sets it
// - freeze default gives power-on lock value; users cannot program it
// - volatile register shadows direction, source and location read-only
// - width bit 1: protect pin is data two, data three is reset when deselected
// - width bit cannot clear while four-wire instruction mode is active; soft reset or 01h without config still reloads it from nv
// - register write updates nv and volatile width; any write may change volatile only
// - lock freezes protect levels, OTP bits, shadows and OTP memory; soft reset still reloads the volatile level from the nv level
// - locked register writes silently skip frozen bits; OTP program fails with error
// - lock clears only on power cycle or hardware reset, not soft reset
// - lock may be set by the same write that updates other fields
// - lock does not block status write disable or width bits
// - reads by 35h and 65h, writes by 01h and 71h
// - volatile width bit 1 selects quad, 0 dual or serial
`timescale 1ns/1ns
`default_nettype none
`include "fcr_params.svh"
module fcr_config_one (
  // clock and hardware reset (power-on or reset pin)
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // decoded command from the spi front end, same clock
  input  wire logic       i_cmd_valid,
  input  wire logic [7:0] i_cmd_opcode,
  input  wire logic [23:0] i_cmd_addr,
  input  wire logic [7:0] i_cmd_status,
  input  wire logic [7:0] i_cmd_config,
  input  wire logic       i_cmd_has_config,
  input  wire logic       i_otp_addr_hit,
  input  wire logic       i_soft_reset,
  // other device state
  input  wire logic       i_uniform_sectors,
  input  wire logic       i_quad_instr_mode,
  input  wire logic       i_quad_instr_nv_set,
  // pins
  input  wire logic       i_cs_n_pin,
  input  wire logic       i_wp_n_pin,
  input  wire logic       i_io3_pin,
  // read data
  output logic [7:0]      o_read_data,
  output logic            o_read_valid,
  // status and controls
  output logic            o_busy,
  output logic            o_program_error,
  output logic [7:0]      o_config_one_nonvolatile,
  output logic [7:0]      o_config_one_volatile,
  output logic [2:0]      o_nonvolatile_protect_level,
  output logic [2:0]      o_volatile_protect_level,
  output logic [2:0]      o_active_protect_level,
  output logic            o_protect_from_bottom,
  output logic            o_params_at_top,
  output logic            o_quad_width,
  output logic            o_write_protect_active,
  output logic            o_io3_reset_req,
  output logic            o_status_write_disable_nv
);
  logic                    cs_n_s;
  logic                    wp_n_s;
  logic                    io3_s;
  logic [7:0]              nv;
  logic [2:0]              nonvolatile_protect_level;
  logic [2:0]              bp_v;
  logic                    wide_v;
  logic                    freeze;
  logic                    status_write_disable_nv;
  logic [7:0]              pend_nv;
  logic [2:0]              pend_nonvolatile_protect_level;
  logic                    pend_srwd;
  fcr_pkg::fcr_state_t     state;
  fcr_pkg::fcr_state_t     next_state;
  logic [7:0]              next_nv;
  logic [2:0]              next_nonvolatile_protect_level;
  logic [2:0]              next_bp_v;
  logic                    next_wide_v;
  logic                    next_freeze;
  logic                    next_srwd;
  logic [7:0]              next_pend_nv;
  logic [2:0]              next_pend_nonvolatile_protect_level;
  logic                    next_pend_srwd;
  logic                    next_perr;
  logic [7:0]              next_rdata;
  logic                    next_rvalid;
  logic                    tmr_start;
  logic [7:0]              tmr_cycles;
  logic                    tmr_busy;
  logic                    tmr_done;
  logic [7:0]              vol_view;
  logic [7:0]              req_nv;
  logic                    is_wrr;
  logic                    is_any_register_write_cmd_nv;
  logic                    is_any_register_write_cmd_v;
  logic                    src_next;

  // pins are asynchronous to the core clock
  fcr_sync u_sync_cs  (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_async(i_cs_n_pin), .o_sync(cs_n_s));
  fcr_sync u_sync_wp  (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_async(i_wp_n_pin), .o_sync(wp_n_s));
  fcr_sync u_sync_io3 (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_async(i_io3_pin), .o_sync(io3_s));

  fcr_busy_timer u_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_start   (tmr_start),
    .i_cycles  (tmr_cycles),
    .o_busy    (tmr_busy),
    .o_done    (tmr_done)
  );

  // volatile view: shadows track the nv bits directly
  always_comb begin
    vol_view                  = 8'h00;
    vol_view[`FCR_BIT_DIR]    = nv[`FCR_BIT_DIR];
    vol_view[`FCR_BIT_SRC]    = nv[`FCR_BIT_SRC];
    vol_view[`FCR_BIT_PARAM]  = nv[`FCR_BIT_PARAM];
    vol_view[`FCR_BIT_WIDE]   = wide_v;
    vol_view[`FCR_BIT_FREEZE] = freeze;
  end

  // command decode
  always_comb begin
    is_wrr     = i_cmd_valid && (i_cmd_opcode == `FCR_OP_REG_WRITE) && (state == fcr_pkg::FCR_IDLE);
    is_any_register_write_cmd_nv = i_cmd_valid && (i_cmd_opcode == `FCR_OP_ANY_WRITE) && (state == fcr_pkg::FCR_IDLE)
                 && (i_cmd_addr == `FCR_ADDR_CFG1_NV);
    is_any_register_write_cmd_v  = i_cmd_valid && (i_cmd_opcode == `FCR_OP_ANY_WRITE) && (state == fcr_pkg::FCR_IDLE)
                 && (i_cmd_addr == `FCR_ADDR_CFG1_V);
    // requested nv image: otp bits only go 0 to 1, freeze default never writable
    req_nv = nv;
    if (is_wrr && i_cmd_has_config || is_any_register_write_cmd_nv) begin
      if (!freeze) begin
        req_nv[`FCR_BIT_DIR]   = nv[`FCR_BIT_DIR]   | i_cmd_config[`FCR_BIT_DIR];
        req_nv[`FCR_BIT_SRC]   = nv[`FCR_BIT_SRC]   | i_cmd_config[`FCR_BIT_SRC];
        req_nv[`FCR_BIT_PARAM] = nv[`FCR_BIT_PARAM] | i_cmd_config[`FCR_BIT_PARAM];
      end
      // width bit ignores the lock, but cannot clear under four-wire mode
      req_nv[`FCR_BIT_WIDE] = i_cmd_config[`FCR_BIT_WIDE] | i_quad_instr_mode;
    end
    if (i_quad_instr_nv_set) begin
      req_nv[`FCR_BIT_WIDE] = 1'b1;
    end
    src_next = req_nv[`FCR_BIT_SRC];
  end

  // command execution and write timing
  always_comb begin
    next_state      = state;
    next_nv         = nv;
    next_nonvolatile_protect_level      = nonvolatile_protect_level;
    next_bp_v       = bp_v;
    next_wide_v     = wide_v;
    next_freeze     = freeze;
    next_srwd       = status_write_disable_nv;
    next_pend_nv    = pend_nv;
    next_pend_nonvolatile_protect_level = pend_nonvolatile_protect_level;
    next_pend_srwd  = pend_srwd;
    next_perr       = o_program_error;
    next_rdata      = o_read_data;
    next_rvalid     = 1'b0;
    tmr_start       = 1'b0;
    tmr_cycles      = 8'(`FCR_V_CYCLES);
    unique case (state)
      fcr_pkg::FCR_IDLE: begin
        if (i_cmd_valid && i_cmd_opcode == `FCR_OP_CFG_READ) begin
          next_rdata  = vol_view;
          next_rvalid = 1'b1;
        end else if (i_cmd_valid && i_cmd_opcode == `FCR_OP_ANY_READ) begin
          next_rdata  = (i_cmd_addr == `FCR_ADDR_CFG1_NV) ? nv :
                        (i_cmd_addr == `FCR_ADDR_CFG1_V) ? vol_view : 8'h00;
          next_rvalid = 1'b1;
        end else if (i_cmd_valid && i_cmd_opcode == `FCR_OP_OTP_PROGRAM && i_otp_addr_hit && freeze) begin
          next_perr = 1'b1;
        end else if (is_wrr) begin
          next_pend_nv   = req_nv;
          next_pend_srwd = i_cmd_status[7];
          next_pend_nonvolatile_protect_level = nonvolatile_protect_level;
          if (!freeze && !src_next) begin
            next_pend_nonvolatile_protect_level = i_cmd_status[4:2];
          end
          if (!freeze && src_next) begin
            next_bp_v = i_cmd_status[4:2];
          end
          next_freeze = freeze | (i_cmd_has_config & i_cmd_config[`FCR_BIT_FREEZE]);
          // only a pure volatile level update earns the short write time
          if (src_next && (req_nv == nv) && (i_cmd_status[7] == status_write_disable_nv)) begin
            tmr_cycles = 8'(`FCR_V_CYCLES);
          end else begin
            tmr_cycles = 8'(`FCR_NV_CYCLES);
          end
          tmr_start   = 1'b1;
          next_state  = fcr_pkg::FCR_BUSY_NV;
        end else if (is_any_register_write_cmd_nv) begin
          next_pend_nv    = req_nv;
          next_pend_nonvolatile_protect_level = nonvolatile_protect_level;
          next_pend_srwd  = status_write_disable_nv;
          tmr_cycles      = 8'(`FCR_NV_CYCLES);
          tmr_start       = 1'b1;
          next_state      = fcr_pkg::FCR_BUSY_NV;
        end else if (is_any_register_write_cmd_v) begin
          // volatile width and freeze bit, width refused to clear in four-wire mode
          next_wide_v = i_cmd_config[`FCR_BIT_WIDE] | i_quad_instr_mode;
          next_freeze = freeze | i_cmd_config[`FCR_BIT_FREEZE];
          tmr_start   = 1'b1;
          next_state  = fcr_pkg::FCR_BUSY_V;
        end else if (i_quad_instr_nv_set) begin
          next_nv[`FCR_BIT_WIDE] = 1'b1;
        end
      end
      fcr_pkg::FCR_BUSY_NV: begin
        if (tmr_done) begin
          next_nv     = pend_nv;
          next_srwd   = pend_srwd;
          next_wide_v = pend_nv[`FCR_BIT_WIDE];
          // setting the source bit forces the nv level to all-protected
          next_nonvolatile_protect_level  = pend_nv[`FCR_BIT_SRC] ? `FCR_BP_ALL : pend_nonvolatile_protect_level;
          next_state  = fcr_pkg::FCR_IDLE;
        end
      end
      fcr_pkg::FCR_BUSY_V: begin
        if (tmr_done) begin
          next_state = fcr_pkg::FCR_IDLE;
        end
      end
    endcase
    // soft reset reloads volatile copies, freeze kept
    if (i_soft_reset && state == fcr_pkg::FCR_IDLE) begin
      next_wide_v = nv[`FCR_BIT_WIDE];
      next_bp_v   = nonvolatile_protect_level;
      next_freeze = freeze;
    end
  end

  // nv bits survive only in reset values here; hardware reset reloads volatile from delivered nv
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state           <= fcr_pkg::FCR_IDLE;
      nv              <= `FCR_NV_DELIVERED;
      nonvolatile_protect_level           <= `FCR_BP_DELIVERED;
      bp_v            <= `FCR_BP_DELIVERED;
      wide_v          <= 1'b0;
      freeze          <= 1'b0;
      status_write_disable_nv         <= 1'b0;
      pend_nv         <= `FCR_NV_DELIVERED;
      pend_nonvolatile_protect_level      <= `FCR_BP_DELIVERED;
      pend_srwd       <= 1'b0;
      o_program_error <= 1'b0;
      o_read_data     <= 8'h00;
      o_read_valid    <= 1'b0;
    end else begin
      state           <= next_state;
      nv              <= next_nv;
      nonvolatile_protect_level           <= next_nonvolatile_protect_level;
      bp_v            <= next_bp_v;
      wide_v          <= next_wide_v;
      freeze          <= next_freeze;
      status_write_disable_nv         <= next_srwd;
      pend_nv         <= next_pend_nv;
      pend_nonvolatile_protect_level      <= next_pend_nonvolatile_protect_level;
      pend_srwd       <= next_pend_srwd;
      o_program_error <= next_perr;
      o_read_data     <= next_rdata;
      o_read_valid    <= next_rvalid;
    end
  end

  // registered views of the state; one cycle behind the source flops
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_busy                      <= 1'b0;
      o_config_one_nonvolatile    <= 8'h00;
      o_config_one_volatile       <= 8'h00;
      o_nonvolatile_protect_level <= 3'h0;
      o_volatile_protect_level    <= 3'h0;
      o_active_protect_level      <= 3'h0;
      o_protect_from_bottom       <= 1'b0;
      o_params_at_top             <= 1'b0;
      o_quad_width                <= 1'b0;
      o_write_protect_active      <= 1'b0;
      o_io3_reset_req             <= 1'b0;
      o_status_write_disable_nv   <= 1'b0;
    end else begin
      o_busy                      <= tmr_busy;
      o_config_one_nonvolatile    <= nv;
      o_config_one_volatile       <= vol_view;
      o_nonvolatile_protect_level <= nonvolatile_protect_level;
      o_volatile_protect_level    <= bp_v;
      o_active_protect_level      <= nv[`FCR_BIT_SRC] ? bp_v : nonvolatile_protect_level;
      o_protect_from_bottom       <= nv[`FCR_BIT_DIR];
      o_params_at_top             <= nv[`FCR_BIT_PARAM] & !i_uniform_sectors;
      o_quad_width                <= wide_v;
      o_write_protect_active      <= !wide_v & !wp_n_s;
      o_io3_reset_req             <= wide_v & cs_n_s & !io3_s;
      o_status_write_disable_nv   <= status_write_disable_nv;
    end
  end
endmodule : fcr_config_one
`default_nettype wire

/* fcr_config_one_props.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fcr_params.svh"
module fcr_config_one_props (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // command side
  input  wire logic       i_cmd_valid,
  input  wire logic [7:0] i_cmd_opcode,
  input  wire logic       i_otp_addr_hit,
  // observed outputs
  input  wire logic       o_read_valid,
  input  wire logic       o_busy,
  input  wire logic       o_program_error,
  input  wire logic [7:0] o_config_one_nonvolatile,
  input  wire logic [7:0] o_config_one_volatile,
  input  wire logic [2:0] o_nonvolatile_protect_level,
  input  wire logic [2:0] o_volatile_protect_level,
  input  wire logic       o_quad_width,
  input  wire logic       o_write_protect_active
);
  localparam int NV_LEN = `FCR_NV_CYCLES;
  localparam int V_LEN  = `FCR_V_CYCLES;
  logic [7:0] blen;
  logic [7:0] next_blen;
  logic [1:0] hist;
  logic [1:0] next_hist;
  logic       go;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // busy run length and recent activity; busy lags the command by two cycles
  always_comb begin
    next_blen = o_busy ? blen + 8'h01 : 8'h00;
    next_hist = {hist[0], o_busy | i_cmd_valid};
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      blen <= 8'h00;
      hist <= 2'h0;
    end else begin
      blen <= next_blen;
      hist <= next_hist;
    end
  end
  // a command the block is surely free to take
  assign go = i_cmd_valid && !o_busy && hist == 2'h0;
  chk_read_answer: assert property (go && (i_cmd_opcode == 8'h35 || i_cmd_opcode == 8'h65) |=> o_read_valid)
    else $error("read gave no data");
  chk_busy_start: assert property (go && (i_cmd_opcode == 8'h01 || i_cmd_opcode == 8'h71) |-> ##2 o_busy)
    else $error("write did not start");
  chk_busy_length: assert property ($fell(o_busy) |-> blen == NV_LEN || blen == V_LEN)
    else $error("write time wrong");
  chk_freeze_hold: assert property (o_config_one_volatile[0] |=> o_config_one_volatile[0])
    else $error("lock bit cleared");
  chk_frozen_level: assert property (o_config_one_volatile[0] && $past(o_config_one_volatile[0])
    |-> $stable(o_nonvolatile_protect_level) && $stable(o_volatile_protect_level)) else $error("locked level moved");
  chk_otp_error: assert property (go && i_cmd_opcode == 8'h42 && i_otp_addr_hit && o_config_one_volatile[0]
    |-> ##[1:4] o_program_error) else $error("locked otp program no error");
  chk_shadow_track: assert property ($stable(o_config_one_nonvolatile)
    |-> {o_config_one_volatile[5], o_config_one_volatile[3:2]} == {o_config_one_nonvolatile[5],
    o_config_one_nonvolatile[3:2]}) else $error("shadow differs");
  chk_quad_select: assert property (o_quad_width == o_config_one_volatile[1])
    else $error("width select wrong");
  chk_wp_ignored: assert property (o_quad_width && $past(o_quad_width) |-> !o_write_protect_active)
    else $error("protect pin active in quad");
endmodule : fcr_config_one_props
bind fcr_config_one fcr_config_one_props props (.*);
`default_nettype wire

/* fcr_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fcr_host_model (
  // clock and answers
  input  wire logic        i_clk_sys,
  input  wire logic        i_busy,
  input  wire logic        i_read_valid,
  input  wire logic [7:0]  i_read_data,
  // decoded command
  output logic             o_cmd_valid,
  output logic [7:0]       o_cmd_opcode,
  output logic [23:0]      o_cmd_addr,
  output logic [7:0]       o_cmd_status,
  output logic [7:0]       o_cmd_config,
  output logic             o_cmd_has_config,
  output logic             o_otp_addr_hit
);
  // idle fields never look like a real command
  initial begin
    o_cmd_valid = 1'b0;
    {o_cmd_opcode, o_cmd_addr, o_cmd_status, o_cmd_config, o_cmd_has_config, o_otp_addr_hit} = '1;
  end
  // one pulse, then wait out busy plus a spare cycle before returning
  task automatic xfer(input logic [7:0] op, input logic [23:0] a, input logic [7:0] st, input logic [7:0] cf,
                      input logic hc, input logic hit, output logic [7:0] rd, output int nb);
    rd = 8'hxx;
    nb = 0;
    @(negedge i_clk_sys);
    {o_cmd_valid, o_cmd_opcode, o_cmd_addr, o_cmd_status, o_cmd_config} = {1'b1, op, a, st, cf};
    {o_cmd_has_config, o_otp_addr_hit} = {hc, hit};
    @(negedge i_clk_sys);
    o_cmd_valid = 1'b0;
    {o_cmd_opcode, o_cmd_addr, o_cmd_status, o_cmd_config} = ~{op, a, st, cf}; // stale value not kept
    // read valid stands for the one cycle after the command edge
    if (i_read_valid) rd = i_read_data;
    @(negedge i_clk_sys);
    while (i_busy && nb < 200) begin
      @(negedge i_clk_sys);
      nb++;
    end
    @(negedge i_clk_sys);
  endtask : xfer
endmodule : fcr_host_model
`default_nettype wire

/* fcr_params.svh */
`ifndef FCR_PARAMS_SVH
`define FCR_PARAMS_SVH

// command opcodes
`define FCR_OP_REG_WRITE      8'h01
`define FCR_OP_CFG_READ       8'h35
`define FCR_OP_ANY_READ       8'h65
`define FCR_OP_ANY_WRITE      8'h71
`define FCR_OP_OTP_PROGRAM    8'h42

// any-register addresses of the two copies
`define FCR_ADDR_CFG1_NV      24'h000002
`define FCR_ADDR_CFG1_V       24'h800002

// field positions
`define FCR_BIT_DIR           5
`define FCR_BIT_SRC           3
`define FCR_BIT_PARAM         2
`define FCR_BIT_WIDE          1
`define FCR_BIT_FREEZE        0

// delivery values
`define FCR_NV_DELIVERED      8'h00
`define FCR_BP_DELIVERED      3'h0
`define FCR_BP_ALL            3'h7

// write times
`define FCR_T_NV_WRITE_NS     2000
`define FCR_T_V_WRITE_NS      50
`define FCR_CLK_PERIOD_NS     50
`define FCR_NV_CYCLES         ((`FCR_T_NV_WRITE_NS + `FCR_CLK_PERIOD_NS - 1) / `FCR_CLK_PERIOD_NS)
`define FCR_V_CYCLES          ((`FCR_T_V_WRITE_NS + `FCR_CLK_PERIOD_NS - 1) / `FCR_CLK_PERIOD_NS)

`endif

/* fcr_pkg.sv */
package fcr_pkg;
  typedef enum logic [1:0] {FCR_IDLE, FCR_BUSY_NV, FCR_BUSY_V} fcr_state_t;
endpackage : fcr_pkg

/* fcr_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module fcr_sync (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  // level in and out
  input  wire logic i_async,
  output logic      o_sync
);
  logic stage1;
  logic next_stage1;
  logic next_sync;

  // two flops, first is read only by the second
  always_comb begin
    next_stage1 = i_async;
    next_sync   = stage1;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    // pins idle high; a low reset value would fake an active pin just after reset
    if (i_rst) begin
      stage1 <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      stage1 <= next_stage1;
      o_sync <= next_sync;
    end
  end
endmodule : fcr_sync
`default_nettype wire

/* flash_config_reg_one_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fcr_params.svh"
module flash_config_reg_one_test;
  logic        i_clk_sys, i_rst, i_soft_reset, i_uniform_sectors, i_quad_instr_mode, i_quad_instr_nv_set;
  logic        i_cs_n_pin, i_wp_n_pin, i_io3_pin, i_cmd_valid, i_cmd_has_config, i_otp_addr_hit;
  logic [7:0]  i_cmd_opcode, i_cmd_status, i_cmd_config, o_read_data, rd;
  logic [23:0] i_cmd_addr;
  logic [7:0]  o_config_one_nonvolatile, o_config_one_volatile;
  logic        o_read_valid, o_busy, o_program_error, o_protect_from_bottom, o_params_at_top;
  logic        o_quad_width, o_write_protect_active, o_io3_reset_req, o_status_write_disable_nv;
  logic [2:0]  o_nonvolatile_protect_level, o_volatile_protect_level, o_active_protect_level;
  int          nb;
  int          n_fail = 0;
  int          n_tests = 0;
  localparam logic [23:0] VA = `FCR_ADDR_CFG1_V;
  fcr_config_one dut (.*);
  fcr_host_model host (.i_clk_sys(i_clk_sys), .i_busy(o_busy), .i_read_valid(o_read_valid),
    .i_read_data(o_read_data), .o_cmd_valid(i_cmd_valid), .o_cmd_opcode(i_cmd_opcode), .o_cmd_addr(i_cmd_addr),
    .o_cmd_status(i_cmd_status), .o_cmd_config(i_cmd_config), .o_cmd_has_config(i_cmd_has_config),
    .o_otp_addr_hit(i_otp_addr_hit));
  // 20 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] st, input logic [7:0] cf,
                     input logic hc, input logic hit);
    host.xfer(op, a, st, cf, hc, hit, rd, nb);
  endtask : cmd
  task automatic idle(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask : idle
  task automatic pulse_soft;
    i_soft_reset = 1'b1;
    idle(1);
    i_soft_reset = 1'b0;
    idle(3);
  endtask : pulse_soft
  task automatic t_delivered;
    cmd(8'h35, 24'h0, 8'h00, 8'h00, 1'b0, 1'b0);
    chk(rd, 8'h00);
    chk(o_config_one_nonvolatile, `FCR_NV_DELIVERED);
    chk(o_nonvolatile_protect_level, `FCR_BP_DELIVERED);
    cmd(8'h01, 24'h0, 8'h14, 8'h00, 1'b1, 1'b0);
    chk(nb[7:0], 8'(`FCR_NV_CYCLES));
    chk(o_nonvolatile_protect_level, 8'h05);
    chk(o_active_protect_level, 8'h05);
  endtask : t_delivered
  task automatic t_width;
    i_quad_instr_nv_set = 1'b1;
    idle(1);
    i_quad_instr_nv_set = 1'b0;
    idle(3);
    chk(o_config_one_nonvolatile[1], 8'h01);
    cmd(8'h01, 24'h0, 8'h14, 8'h02, 1'b1, 1'b0);
    chk(o_config_one_nonvolatile[1], 8'h01);
    chk(o_quad_width, 8'h01);
    i_wp_n_pin = 1'b0;
    i_io3_pin = 1'b0;
    idle(4);
    chk(o_write_protect_active, 8'h00);
    chk(o_io3_reset_req, 8'h01);
    i_io3_pin = 1'b1;
    i_quad_instr_mode = 1'b1;
    cmd(8'h71, VA, 8'h00, 8'h00, 1'b0, 1'b0);
    chk(o_quad_width, 8'h01);
    i_quad_instr_mode = 1'b0;
    cmd(8'h71, VA, 8'h00, 8'h00, 1'b0, 1'b0);
    chk(o_quad_width, 8'h00);
    chk(o_config_one_nonvolatile[1], 8'h01);
    chk(o_write_protect_active, 8'h01);
    i_wp_n_pin = 1'b1;
  endtask : t_width
  task automatic t_param;
    cmd(8'h01, 24'h0, 8'h14, 8'h04, 1'b1, 1'b0);
    chk(o_params_at_top, 8'h01);
    chk(o_protect_from_bottom, 8'h00);
    cmd(8'h01, 24'h0, 8'h14, 8'h20, 1'b1, 1'b0);
    chk(o_params_at_top, 8'h01);
    chk(o_protect_from_bottom, 8'h01);
    chk(o_program_error, 8'h00);
    cmd(8'h65, VA, 8'h00, 8'h00, 1'b0, 1'b0);
    chk(rd, 8'h24);
    i_uniform_sectors = 1'b1;
    idle(2);
    chk(o_params_at_top, 8'h00);
    i_uniform_sectors = 1'b0;
  endtask : t_param
  task automatic t_source;
    cmd(8'h01, 24'h0, 8'h14, 8'h08, 1'b1, 1'b0);
    chk(o_nonvolatile_protect_level, 8'h07);
    chk(o_config_one_volatile[3], 8'h01);
    cmd(8'h01, 24'h0, 8'h08, 8'h00, 1'b0, 1'b0);
    chk(nb[7:0], 8'(`FCR_V_CYCLES));
    chk(o_volatile_protect_level, 8'h02);
    chk(o_nonvolatile_protect_level, 8'h07);
    chk(o_active_protect_level, 8'h02);
    pulse_soft();
    chk(o_volatile_protect_level, 8'h07);
  endtask : t_source
  task automatic t_freeze;
    cmd(8'h71, VA, 8'h03, 8'h03, 1'b0, 1'b0);
    chk(o_config_one_volatile[0], 8'h01);
    chk(o_quad_width, 8'h01);
    cmd(8'h71, VA, 8'h01, 8'h01, 1'b0, 1'b0);
    chk(o_quad_width, 8'h00);
    cmd(8'h01, 24'h0, 8'h84, 8'h00, 1'b0, 1'b0);
    chk(o_volatile_protect_level, 8'h07);
    chk(o_program_error, 8'h00);
    chk(o_status_write_disable_nv, 8'h01);
    cmd(8'h42, 24'h0, 8'h00, 8'h00, 1'b0, 1'b1);
    chk(o_program_error, 8'h01);
    pulse_soft();
    chk(o_config_one_volatile[0], 8'h01);
    i_rst = 1'b1;
    idle(2);
    i_rst = 1'b0;
    idle(2);
    chk(o_config_one_volatile[0], 8'h00);
  endtask : t_freeze
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // watchdog well past the few hundred cycles the tests need
  initial begin
    #(50 * 20000);
    n_fail++;
    final_report();
  end
  // reset for six cycles, then the scenarios
  initial begin
    {i_rst, i_soft_reset, i_uniform_sectors, i_quad_instr_mode, i_quad_instr_nv_set} = 5'b10000;
    {i_cs_n_pin, i_wp_n_pin, i_io3_pin} = 3'b111;
    idle(6);
    i_rst = 1'b0;
    idle(1);
    t_delivered();
    t_width();
    t_param();
    t_source();
    t_freeze();
    final_report();
  end
endmodule : flash_config_reg_one_test
`default_nettype wire
